// File: rtl/hni_pkg.sv
package hni_pkg;

    // Data path and sideband widths
    localparam int HNI_DATA_W = 32;
    localparam int HNI_STRB_W = HNI_DATA_W / 8;
    localparam int HNI_ADDR_W = 32;
    localparam int HNI_QOS_W  = 4;
    localparam int HNI_TGT_W  = 4;
    localparam int HNI_LEN_W  = 5;

    // Register offsets (byte addresses on the APB port)
    localparam logic [11:0] HNI_CTRL_OFF = 12'h000;
    localparam logic [11:0] HNI_QOS_OFF  = 12'h004;
    localparam logic [11:0] HNI_STAT_OFF = 12'h008;

    // Control register fields and reset value
    localparam int          HNI_CTRL_PROMO_BIT = 0;
    localparam int          HNI_CTRL_EWR_BIT   = 1;
    localparam int          HNI_CTRL_QMODE_LSB = 4;
    localparam int          HNI_CTRL_SPLIT_LSB = 8;
    localparam logic [31:0] HNI_CTRL_RST       = 32'h0000_1000;

    // Regulator register fields and reset value
    localparam int          HNI_QOS_PER_LSB = 0;
    localparam int          HNI_QOS_LIM_LSB = 8;
    localparam int          HNI_QOS_HI_LSB  = 16;
    localparam int          HNI_QOS_LO_LSB  = 20;
    localparam logic [31:0] HNI_QOS_RST     = 32'h0008_0F03;

    // Regulator modes
    localparam logic [1:0] HNI_QM_OFF  = 2'h0;
    localparam logic [1:0] HNI_QM_SOFT = 2'h1;
    localparam logic [1:0] HNI_QM_HARD = 2'h2;

    // Bus encodings
    localparam logic [1:0] HNI_TRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HNI_BURST_INCR   = 3'h1;
    localparam logic [1:0] HNI_RSP_OKAY     = 2'h0;
    localparam logic [1:0] HNI_RSP_EXOKAY   = 2'h1;
    localparam logic [1:0] HNI_RSP_SLVERR   = 2'h2;
    localparam logic [1:0] HNI_RSP_DECERR   = 2'h3;

    // Data-phase state machine
    typedef enum logic [6:0] {
        HNI_ST_IDLE  = 7'h01,
        HNI_ST_DATA  = 7'h02,
        HNI_ST_RWAIT = 7'h04,
        HNI_ST_WRSP  = 7'h08,
        HNI_ST_HOLD  = 7'h10,
        HNI_ST_ERR1  = 7'h20,
        HNI_ST_ERR2  = 7'h40
    } hni_state_t;

    // Registered address phase
    typedef struct packed {
        logic [HNI_ADDR_W-1:0] addr;
        logic                  write;
        logic [2:0]            size;
        logic [HNI_LEN_W-1:0]  len;
        logic                  excl;
        logic                  share;
    } hni_aph_t;

    // Request flit: reads and writes share one channel
    typedef struct packed {
        logic                  write;
        logic                  hdr;
        logic [HNI_LEN_W-1:0]  len;
        logic [HNI_TGT_W-1:0]  tgt;
        logic [HNI_ADDR_W-1:0] addr;
        logic [2:0]            size;
        logic                  excl;
        logic                  share;
        logic [HNI_QOS_W-1:0]  qos;
        logic [HNI_DATA_W-1:0] data;
    } hni_req_t;

    // Response flit: one fragment with the byte lanes it carries
    typedef struct packed {
        logic                  write;
        logic                  last;
        logic [1:0]            resp;
        logic [HNI_STRB_W-1:0] lanes;
        logic [HNI_DATA_W-1:0] data;
    } hni_rsp_t;

endpackage

// File: rtl/hni_ahb_ingress_ni.sv
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
// Functional notes
// - Slave variant has select, ready input and ready output.
// - Mirrored-master variant ignores select and ready input for direct master hookup.
// - AHB transfers become request flits; response flits become AHB responses.
// - A new read waits while any issued write is outstanding.
// - With promotion on, aligned undefined INCR bursts become four-beat bursts.
// - Split bursts at stripe boundaries or at the programmed split size.
// - Early write response answers writes early; later reads wait for completion.
// - Hard and soft bandwidth regulators, mode and settings in registers.
// - Register stages isolate AHB timing from network timing.
// - One shared request channel and one shared response channel.
// - Accept responses from equal, narrower or wider egress widths.
// - Gather narrow read fragments into one full-width beat.
// - Merged status: error above okay above exclusive okay.
// - Data widths of 512 or 1024 bits are not allowed.
// - Multi-copy atomicity holds only with early write response off.
// - Shareable exclusive accesses leave as non-shareable exclusive.
// - Address phase is registered to line up with its data phase.
// - Request output always buffered; depacketizer output always registered.
// - Optional stages on write data, packetizer input, AHB response, network response.

// Optional valid/ready register slice; pass-through when EN is 0
module hni_slice #(
    parameter type T  = logic,
    parameter bit  EN = 1'b1
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic in_valid,
    input  wire T     in_data,
    output logic      in_ready,
    output logic      out_valid,
    output T          out_data,
    input  wire logic out_ready
);
    generate
        if (EN)
        begin : g_reg
            logic valid_q;
            T     data_q;
            assign in_ready  = !valid_q || out_ready;
            assign out_valid = valid_q;
            assign out_data  = data_q;
            // Holds the flit stable until the far side takes it
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    valid_q <= 1'b0;
                else if (in_ready)
                    valid_q <= in_valid;
            end
            always_ff @(posedge pclk)
            begin
                if (in_valid && in_ready)
                    data_q <= in_data;
            end
        end
        else
        begin : g_wire
            assign in_ready  = out_ready;
            assign out_valid = in_valid;
            assign out_data  = in_data;
        end
    endgenerate
endmodule // hni_slice

module hni_ahb_ingress_ni
    import hni_pkg::*;
#(
    parameter bit MIRROR        = 1'b0,
    parameter bit WDATA_STAGE   = 1'b0,
    parameter bit PKT_IN_STAGE  = 1'b0,
    parameter bit HRSP_STAGE    = 1'b0,
    parameter bit NET_RSP_STAGE = 1'b0,
    parameter int STRIPE_LOG2   = 12,
    parameter int OUT_W         = 6
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    input  wire logic                  hsel,
    input  wire logic                  hready_in,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [HNI_ADDR_W-1:0] haddr,
    input  wire logic [2:0]            hsize,
    input  wire logic [2:0]            hburst,
    input  wire logic                  hexcl,
    input  wire logic                  hshare,
    input  wire logic [HNI_DATA_W-1:0] hwdata,
    output logic                       hready_out,
    output logic                       hresp,
    output logic                       hexokay,
    output logic [HNI_DATA_W-1:0]      hrdata,
    output logic                       req_valid,
    output hni_req_t                   req,
    input  wire logic                  req_ready,
    input  wire logic                  rsp_valid,
    input  wire hni_rsp_t              rsp,
    output logic                       rsp_ready
);

    // Severity rank: errors above okay above exclusive okay
    function automatic logic [1:0] rank(input logic [1:0] r);
        rank = r[1] ? 2'h2 : (r == HNI_RSP_OKAY) ? 2'h1 : 2'h0;
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == HNI_CTRL_OFF) || (a == HNI_QOS_OFF) || (a == HNI_STAT_OFF);
    endfunction

    hni_state_t                 state_q, state_d;
    hni_aph_t                   aph_q;
    hni_req_t                   pkt, buf_data;
    hni_rsp_t                   rin;
    logic [31:0]                ctrl_q, qos_q;
    logic [HNI_LEN_W-1:0]       beat_q, blen;
    logic                       hdr_q, dcyc_q, first_q, promo;
    logic [OUT_W-1:0]           wr_out_q;
    logic [7:0]                 tok_q, per_q;
    logic [HNI_DATA_W-1:0]      wdata_q, acc_q, m_data;
    logic [1:0]                 acc_resp_q, m_resp;
    logic                       sel, rdy_in, addr_take, push, rd_haz, qos_blk;
    logic                       sa_ready, buf_valid, buf_ready, rin_valid;
    logic                       rd_done, wr_done, fin_err;
    logic [1:0]                 qmode;
    logic [4:0]                 split;

    assign qmode = ctrl_q[HNI_CTRL_QMODE_LSB +: 2];
    assign split = ctrl_q[HNI_CTRL_SPLIT_LSB +: 5];

    // Mirrored variant has no decoder in front, so select and ready are implied
    assign sel    = MIRROR ? 1'b1 : hsel;
    assign rdy_in = MIRROR ? 1'b1 : hready_in;
    assign addr_take = ((state_q == HNI_ST_IDLE) || (state_q == HNI_ST_ERR2))
                       && sel && rdy_in && htrans[1];

    // Burst length from the burst code; promote aligned INCR to four beats
    assign promo = ctrl_q[HNI_CTRL_PROMO_BIT] && (hburst == HNI_BURST_INCR)
                   && ((haddr[7:0] & ((8'h04 << hsize) - 8'h01)) == 8'h00);
    always_comb
    begin
        blen = 5'h00;
        case (hburst[2:1])
            2'h1:    blen = 5'h04;
            2'h2:    blen = 5'h08;
            2'h3:    blen = 5'h10;
            default: blen = hburst[0] ? 5'h00 : 5'h01;
        endcase
        if (promo)
            blen = 5'h04;
    end

    // Capture the address phase; the lock indication has no input at all
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            aph_q <= '0;
        else if (addr_take)
        begin
            aph_q.addr  <= haddr;
            aph_q.write <= hwrite;
            aph_q.size  <= hsize;
            aph_q.len   <= blen;
            aph_q.excl  <= hexcl;
            aph_q.share <= hshare && !hexcl;
        end
    end

    // Start a new network request at burst start, stripe edge or split size
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            beat_q <= 5'h00;
            hdr_q  <= 1'b0;
        end
        else if (addr_take)
        begin
            if (htrans == HNI_TRANS_NONSEQ || beat_q == split
                || haddr[STRIPE_LOG2-1:0] == '0)
            begin
                beat_q <= 5'h01;
                hdr_q  <= 1'b1;
            end
            else
            begin
                beat_q <= beat_q + 5'h01;
                hdr_q  <= 1'b0;
            end
        end
    end

    // Optional write-data stage costs one data-phase cycle per write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wdata_q <= '0;
            dcyc_q  <= 1'b0;
        end
        else
        begin
            wdata_q <= hwdata;
            dcyc_q  <= (state_q == HNI_ST_DATA) && !push;
        end
    end

    // Reads never pass an outstanding write, early-answered or not
    assign rd_haz  = !aph_q.write && (wr_out_q != '0);
    assign qos_blk = (qmode == HNI_QM_HARD) && (tok_q == 8'h00);
    assign push    = (state_q == HNI_ST_DATA) && sa_ready && !rd_haz && !qos_blk
                     && (!aph_q.write || !WDATA_STAGE || dcyc_q);

    // Packetize; soft regulation demotes priority instead of stalling
    always_comb
    begin
        pkt       = '0;
        pkt.write = aph_q.write;
        pkt.hdr   = hdr_q;
        pkt.len   = aph_q.len;
        pkt.tgt   = aph_q.addr[HNI_ADDR_W-1 -: HNI_TGT_W];
        pkt.addr  = aph_q.addr;
        pkt.size  = aph_q.size;
        pkt.excl  = aph_q.excl;
        pkt.share = aph_q.share;
        pkt.qos   = (qmode == HNI_QM_SOFT && tok_q == 8'h00)
                    ? qos_q[HNI_QOS_LO_LSB +: 4] : qos_q[HNI_QOS_HI_LSB +: 4];
        pkt.data  = (aph_q.write && WDATA_STAGE) ? wdata_q : hwdata;
    end

    // Packetizer input stage, then the request buffer that always exists
    hni_slice #(.T(hni_req_t), .EN(PKT_IN_STAGE)) u_pkt_in (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (push),
        .in_data   (pkt),
        .in_ready  (sa_ready),
        .out_valid (buf_valid),
        .out_data  (buf_data),
        .out_ready (buf_ready)
    );
    hni_slice #(.T(hni_req_t), .EN(1'b1)) u_req_buf (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (buf_valid),
        .in_data   (buf_data),
        .in_ready  (buf_ready),
        .out_valid (req_valid),
        .out_data  (req),
        .out_ready (req_ready)
    );

    // Response input: every fragment is taken, one read is in flight at most
    hni_slice #(.T(hni_rsp_t), .EN(NET_RSP_STAGE)) u_rsp_in (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (rsp_valid),
        .in_data   (rsp),
        .in_ready  (),
        .out_valid (rin_valid),
        .out_data  (rin),
        .out_ready (1'b1)
    );
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rsp_ready <= 1'b0;
        else
            rsp_ready <= 1'b1;
    end

    // Gather lanes of narrow fragments; wider targets fill all lanes at once
    always_comb
    begin
        m_data = first_q ? '0 : acc_q;
        for (int i = 0; i < HNI_STRB_W; i++)
        begin
            if (rin.lanes[i])
                m_data[i*8 +: 8] = rin.data[i*8 +: 8];
        end
        m_resp = (first_q || rank(rin.resp) > rank(acc_resp_q)) ? rin.resp : acc_resp_q;
    end
    assign rd_done = rin_valid && !rin.write && rin.last;
    assign wr_done = rin_valid && rin.write && rin.last;
    assign fin_err = m_resp[1];

    // Depacketizer output register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_q      <= '0;
            acc_resp_q <= HNI_RSP_OKAY;
            first_q    <= 1'b1;
        end
        else if (rin_valid && !rin.write)
        begin
            acc_q      <= m_data;
            acc_resp_q <= m_resp;
            first_q    <= rin.last;
        end
    end

    // Writes in flight; counted at packetizing so hazards see queued flits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wr_out_q <= '0;
        else
            wr_out_q <= wr_out_q + OUT_W'(push && aph_q.write) - OUT_W'(wr_done);
    end

    // Token bucket shared by both regulator modes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tok_q <= 8'h00;
            per_q <= 8'h00;
        end
        else
        begin
            per_q <= (per_q >= qos_q[HNI_QOS_PER_LSB +: 8]) ? 8'h00 : per_q + 8'h01;
            tok_q <= tok_q
                     + 8'((per_q >= qos_q[HNI_QOS_PER_LSB +: 8])
                          && (tok_q < qos_q[HNI_QOS_LIM_LSB +: 8]))
                     - 8'(push && (tok_q != 8'h00));
        end
    end

    // Data-phase sequencing
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            HNI_ST_IDLE, HNI_ST_ERR2:
                state_d = addr_take ? HNI_ST_DATA : HNI_ST_IDLE;
            HNI_ST_DATA:
                if (push)
                begin
                    if (!aph_q.write)
                        state_d = HNI_ST_RWAIT;
                    else if (!ctrl_q[HNI_CTRL_EWR_BIT])
                        state_d = HNI_ST_WRSP;
                    else
                        state_d = HRSP_STAGE ? HNI_ST_HOLD : HNI_ST_IDLE;
                end
            HNI_ST_RWAIT:
                if (rd_done)
                    state_d = fin_err ? HNI_ST_ERR1
                              : (HRSP_STAGE ? HNI_ST_HOLD : HNI_ST_IDLE);
            HNI_ST_WRSP:
                if (wr_done && wr_out_q == OUT_W'(1))
                    state_d = rin.resp[1] ? HNI_ST_ERR1
                              : (HRSP_STAGE ? HNI_ST_HOLD : HNI_ST_IDLE);
            HNI_ST_HOLD:
                state_d = HNI_ST_IDLE;
            HNI_ST_ERR1:
                state_d = HNI_ST_ERR2;
            default:
                state_d = HNI_ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= HNI_ST_IDLE;
        else
            state_q <= state_d;
    end

    // AHB answer flops; never split or retry, only okay or two-cycle error
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hready_out <= 1'b1;
            hresp      <= 1'b0;
            hexokay    <= 1'b0;
            hrdata     <= '0;
        end
        else
        begin
            hready_out <= (state_d == HNI_ST_IDLE) || (state_d == HNI_ST_ERR2);
            hresp      <= (state_d == HNI_ST_ERR1) || (state_d == HNI_ST_ERR2);
            if (addr_take)
                hexokay <= 1'b0;
            else if (rd_done)
                hexokay <= (m_resp == HNI_RSP_EXOKAY);
            if (rd_done)
                hrdata <= m_data;
        end
    end

    // APB slave: no wait states, unmapped offsets answer with an error
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            ctrl_q  <= HNI_CTRL_RST;
            qos_q   <= HNI_QOS_RST;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped(paddr);
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite)
            begin
                case (paddr)
                    HNI_CTRL_OFF: prdata <= ctrl_q;
                    HNI_QOS_OFF:  prdata <= qos_q;
                    HNI_STAT_OFF: prdata <= {9'h000, state_q, tok_q, 2'h0, wr_out_q};
                    default:      prdata <= 32'h0000_0000;
                endcase
            end
            if (psel && penable && pready && pwrite && paddr == HNI_CTRL_OFF)
                ctrl_q <= pwdata & 32'h0000_1F33;
            if (psel && penable && pready && pwrite && paddr == HNI_QOS_OFF)
                qos_q <= pwdata & 32'h00FF_FFFF;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_DATA_WIDTH: assert property (HNI_DATA_W != 512 && HNI_DATA_W != 1024)
        else $error("unsupported data width");
    AST_READ_HAZARD: assert property (rd_haz |-> !push)
        else $error("read issued while writes outstanding");
    AST_STALL: assert property (state_q == HNI_ST_DATA && !push |=> !hready_out)
        else $error("ready high while request stalled");
    AST_ERR_TWO_CYCLE: assert property (state_q == HNI_ST_ERR1 |->
        hresp && !hready_out ##1 hresp && hready_out)
        else $error("error response not two cycles");
    AST_EXCL_NONSHARE: assert property (req_valid && req.excl |-> !req.share)
        else $error("exclusive left as shareable");
    AST_SPLIT: assert property (addr_take && htrans[0] && beat_q == split |=> hdr_q)
        else $error("burst not split at split size");
    AST_NO_EWR: assert property (push && aph_q.write && !ctrl_q[HNI_CTRL_EWR_BIT]
        |=> state_q == HNI_ST_WRSP && !hready_out)
        else $error("write answered before completion");
    AST_MERGE_PRIO: assert property (rin_valid && !rin.write && !rin.last
        && rin.resp[1] |=> acc_resp_q[1] throughout (!first_q)[*1])
        else $error("error status lost in merge");
    AST_REQ_BUF: assert property (req_valid && !req_ready |=> req_valid && $stable(req))
        else $error("request buffer dropped a flit");
    AST_HARD_QOS: assert property (qos_blk |-> !push ##1 tok_q <= $past(tok_q) + 8'h01)
        else $error("hard regulator let a request through");

    COV_READ: cover property (state_q == HNI_ST_RWAIT ##[1:50] hready_out && !hresp);
    COV_EARLY_WRITE: cover property (push && aph_q.write && ctrl_q[HNI_CTRL_EWR_BIT]);
    COV_ERROR: cover property (state_q == HNI_ST_ERR1);
    COV_FRAGS: cover property (rin_valid && !rin.write && !rin.last);

endmodule // hni_ahb_ingress_ni

// File: test/hni_net_model.sv
`timescale 1ns/1ns
// Network side: answers flits in order, a read as two half-word fragments
module hni_net_model
    import hni_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       slow,
    input  wire logic [3:0] codes,
    input  wire logic       req_valid,
    input  wire hni_req_t   req,
    output logic            req_ready,
    output logic            rsp_valid,
    output hni_rsp_t        rsp,
    output int              wr_open
);
    hni_req_t    q[$];
    logic        sec_q;
    logic [31:0] p;
    int          n;
    assign req_ready = !slow; // Random stalls, like a busy router
    // Unused lanes carry the inverse, so a wrong gather cannot pass
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q.delete();
            n = 0;
            sec_q <= 1'b0;
            rsp_valid <= 1'b0;
            rsp <= '0;
            wr_open <= 0;
        end
        else
        begin
            rsp_valid <= q.size() != 0 && !slow;
            if (q.size() != 0 && !slow)
            begin
                p = q[0].addr ^ 32'hA5A5_5A5A;
                rsp <= {q[0].write, q[0].write || sec_q, sec_q ? codes[3:2] : codes[1:0],
                    sec_q ? {4'hC, p[31:16], ~p[15:0]} : {4'h3, ~p[31:16], p[15:0]}};
                sec_q <= !sec_q && !q[0].write;
                n -= (q[0].write || sec_q) ? int'(q[0].write) : 0;
                if (q[0].write || sec_q)
                    q.delete(0);
            end
            else
                rsp.data <= ~rsp.data;
            if (req_valid && req_ready)
                q.push_back(req);
            n += (req_valid && req_ready) ? int'(req.write) : 0;
            wr_open <= n;
        end
    end
endmodule // hni_net_model

// File: test/tb_top.sv
`timescale 1ns/1ns
// Drives both buses, notes expectations in queues; a monitor compares
module tb_top;
    import hni_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, hwrite = 0, hexcl = 0;
    logic slow = 0, rd_on = 0, pready, pslverr, hready_out, hresp, hexokay, req_valid;
    logic req_ready, rsp_valid, rsp_ready;
    logic [1:0] htrans = '0;
    logic [3:0] codes = '0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, hwdata = '0, haddr = '0, prdata, hrdata, a, d;
    logic [33:0] e, exp_q[$];
    logic [31:0] wq[$];
    logic [4:0] lq[$];
    logic [2:0] hburst = '0;
    logic hshare = 0, pr = 0;
    logic [5:0] mt[5] = '{6'h00, 6'h25, 6'h04, 6'h19, 6'h13};
    hni_req_t req;
    hni_rsp_t rsp;
    int wr_open, fail_count = 0, num_checks = 0;
    always #2 pclk = ~pclk;
    // Back-pressure at random
    always @(posedge pclk) slow <= $urandom % 4 == 0;
    hni_ahb_ingress_ni dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .hsel(1'b1), .hready_in(1'b1), .htrans, .hwrite,
        .haddr, .hsize(3'h2), .hburst, .hexcl, .hshare, .hwdata, .hready_out,
        .hresp, .hexokay, .hrdata, .req_valid, .req, .req_ready, .rsp_valid, .rsp, .rsp_ready);
    hni_net_model net_u (.pclk, .presetn, .slow, .codes, .req_valid, .req, .req_ready,
        .rsp_valid, .rsp, .wr_open);
    task automatic chk(string nm, logic [33:0] x, logic [33:0] s);
        num_checks++;
        if (x !== s)
        begin
            fail_count++;
            $display("BAD %s exp %h got %h", nm, x, s);
        end
    endtask
    task automatic apb(logic w, logic [11:0] ad, logic [31:0] dd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= dd;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk); // One idle edge, so psel is never driven twice in a step
    endtask
    task automatic ahb(logic w, logic [31:0] ad, logic [31:0] dd);
        logic b;
        b = 1'($urandom);
        lq.push_back(!b ? 5'h01 : (pr && ad[3:0] == 4'h0) ? 5'h04 : 5'h00);
        htrans <= HNI_TRANS_NONSEQ; // No lock indication is ever driven
        hburst <= {2'b00, b};
        hshare <= 1'($urandom);
        hwrite <= w;
        haddr <= ad;
        do @(posedge pclk); while (hready_out !== 1'b1);
        htrans <= 2'h0;
        hwdata <= dd;
        rd_on <= !w;
        do @(posedge pclk); while (hready_out !== 1'b1);
        rd_on <= 1'b0;
    endtask
    // Each result takes the oldest note; read data is ignored on error
    always @(posedge pclk)
    begin
        if (psel && penable && pready && !pwrite)
            chk("apb", exp_q.pop_front(), {1'b0, pslverr, prdata});
        if (rd_on && hready_out)
            e = exp_q.pop_front();
        if (rd_on && hready_out)
            chk("ahb", e, {hexokay, hresp, e[32] ? e[31:0] : hrdata});
        if (req_valid && req_ready && req.write)
            chk("wdata", {2'b0, wq.pop_front()}, {2'b0, req.data});
        if (req_valid && req_ready && !req.write)
            chk("hazard", 34'h0, 34'(wr_open));
        if (req_valid && req_ready && req.excl)
            chk("share", 34'h0, {33'h0, req.share});
        if (req_valid && req_ready)
            chk("flit", {28'h0, 1'b1, lq.pop_front()}, {28'h0, req.hdr, req.len});
        if (rsp_valid)
            chk("rsp_ready", 34'h1, {33'h0, rsp_ready});
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial
    begin
        #100000;
        fail_count++;
        stop_test();
    end
    // Registers, then write/read pairs with early response off and on, then merges
    initial
    begin
        void'($urandom(32'he1db));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        exp_q.push_back({2'b00, HNI_CTRL_RST});
        apb(1'b0, HNI_CTRL_OFF, 32'h0);
        exp_q.push_back({2'b00, HNI_QOS_RST});
        apb(1'b0, HNI_QOS_OFF, 32'h0);
        exp_q.push_back({2'b01, 32'h0});
        apb(1'b0, 12'h00C, 32'h0);
        // Early response off/on, then promotion with soft and hard regulation
        for (int m = 0; m < 4; m++)
        begin
            pr = m[1];
            apb(1'b1, HNI_CTRL_OFF, HNI_CTRL_RST | (32'(m[0]) << HNI_CTRL_EWR_BIT)
                | (32'(m[1]) << HNI_CTRL_PROMO_BIT)
                | (32'(m[1] ? (m[0] ? HNI_QM_HARD : HNI_QM_SOFT) : HNI_QM_OFF)
                   << HNI_CTRL_QMODE_LSB));
            repeat (6)
            begin
                a = $urandom & 32'h0000_0FFC;
                d = $urandom;
                wq.push_back(d);
                ahb(1'b1, a, d);
                exp_q.push_back({2'b00, a ^ 32'hA5A5_5A5A});
                ahb(1'b0, a, 32'h0);
            end
        end
        hexcl <= 1'b1;
        foreach (mt[i])
        begin
            codes <= mt[i][3:0];
            exp_q.push_back({mt[i][5:4], 32'h0000_0010 ^ 32'hA5A5_5A5A});
            ahb(1'b0, 32'h0000_0010, 32'h0);
        end
        stop_test();
    end
endmodule // tb_top
